/* File: src/pulse_timer_unit_defines.svh */
// Purpose: Offsets, field positions, reset values and codes of the
//          six-channel pulse timer unit.
// Assumes: Byte addresses on an 8-bit Wishbone address, one word each.
// Notes:   Definitions only.
`ifndef PULSE_TIMER_UNIT_DEFINES_SVH
`define PULSE_TIMER_UNIT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_CTRL_BASE   8'h00
`define OFS_START       8'h18
`define OFS_SYNC        8'h1C
`define OFS_CNT_BASE    8'h20
`define OFS_PHASE       8'h38
`define OFS_BUFFER      8'h3C
`define OFS_PIN_FUNC    8'h40
`define OFS_IRQ_STATUS  8'h44
`define OFS_IRQ_MASK    8'h48
`define OFS_GR_BASE     8'h80

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define CLR_MSB         7
`define CLR_LSB         5
`define EDGE_MSB        4
`define EDGE_LSB        3
`define PSC_MSB         2
`define PSC_LSB         0
`define CTRL_RESET      8'h00
`define CTRL_MASK_NARROW 8'h7F
`define PHASE_MASK      6'h36

// Clearing source codes.
`define CLR_GR_A        3'h1
`define CLR_GR_B        3'h2
`define CLR_GR_C        3'h5
`define CLR_GR_D        3'h6
`define CLR_SYNC_LOW    2'h3

// Clock source codes.
`define PSC_DIV1        3'h0
`define PSC_DIV4        3'h1
`define PSC_DIV16       3'h2
`define PSC_DIV64       3'h3
`define PSC_CASCADE     3'h7

// Prescaler bit whose square wave is the divided clock.
`define DIV4_BIT        1
`define DIV16_BIT       3
`define DIV64_BIT       5

`endif

/* File: src/pulse_timer_unit_pkg.sv */
// Purpose: Types shared by the pulse timer unit and its users.
// Assumes: Classic Wishbone with 32-bit data.
// Notes:   Constants live in the defines header.
package pulse_timer_unit_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

endpackage : pulse_timer_unit_pkg

/* File: src/pulse_timer_unit.sv */
// Purpose: Six-channel pulse timer: clock selection, edge selection,
//          phase counting, counter clearing, capture/compare pins.
// Assumes: Wishbone slave on i_clk; pins and external clocks are async.
// Summary of operation
// - every channel owns an 8-bit read/write control register.
// - control bits 7..5 choose the counter clearing event.
// - control bits 4..3 choose the counting edge of the input clock.
// - both-edge counting steps on rising and falling edges.
// - phase counting on channels 1,2,4,5 overrides the edge selection.
// - edge selection applies to divide-by-4 and slower, not undivided.
// - counting another channel's overflow ignores the edge selection.
// - inputs A,B clock any channel; phases for channels 1 and 5.
// - input C clocks any channel, D all but 1 and 4; phases for channels 2 and 4.
// - one two-way pin per general register; four on 0 and 3.
// - start and sync registers are shared by all six channels.
// - edge code 00 rising, 01 falling, 1x both edges.
// - codes 5 and 6 clear on C/D match, not in buffer use.
// - bit 7 of control on channels 1,2,4,5 reads zero, ignores writes.
// - channel 0 clock codes: div 1,4,16,64, then inputs A, B, C, D.
`timescale 1ns/1ps
module pulse_timer_unit
  import pulse_timer_unit_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_ce,
  input  wire wb_req_s    i_wb,
  output wb_rsp_s         o_wb,
  input  wire logic       i_ext_clock_in_a,
  input  wire logic       i_ext_clock_in_b,
  input  wire logic       i_ext_clock_in_c,
  input  wire logic       i_ext_clock_in_d,
  input  wire logic [15:0] i_gp_pin,
  output logic      [15:0] o_gp_pin,
  output logic      [15:0] o_gp_pin_oe,
  output logic             o_irq
);
`include "pulse_timer_unit_defines.svh"

  localparam int NCH = 6;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic int pin_idx(input int ch, input int k);
    int base;
    case (ch)
      0:       base = 0;
      1:       base = 4;
      2:       base = 6;
      3:       base = 8;
      4:       base = 12;
      default: base = 14;
    endcase
    return base + k;
  endfunction : pin_idx

  function automatic logic gr_exists(input int ch, input int k);
    return (k < 2) || (ch == 0) || (ch == 3);
  endfunction : gr_exists

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input wb_req_s     req);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (req.sel[b]) begin
        res[b*8 +: 8] = req.dat[b*8 +: 8];
      end
    end
    return res;
  endfunction : wmerge

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]       ctrl_reg     [NCH];
  logic [CNT_W-1:0] cnt_reg      [NCH];
  logic [CNT_W-1:0] gr_reg       [NCH][4];
  logic [NCH-1:0]   start_reg;
  logic [NCH-1:0]   sync_reg;
  logic [NCH-1:0]   phase_reg;
  logic [1:0]       buffer_reg;
  logic [15:0]      pin_func_reg;
  logic [21:0]      irq_status_reg;
  logic [21:0]      irq_mask_reg;
  logic [NCH-1:0]   ovf_pulse_reg;
  logic [5:0]       presc_reg;
  logic [3:0]       ext_meta_reg, ext_sync_reg, ext_prev_reg;
  logic [15:0]      pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic [15:0]      pin_out_reg;
  logic             ack_reg;
  logic [31:0]      rdat_reg;
  logic             irq_reg;

  logic             access;
  logic             wr;
  logic [31:0]      rdata;
  logic [3:0]       ext_rise, ext_fall;
  logic [15:0]      pin_rise;
  logic [2:0]       pr_rise, pr_fall;
  logic [NCH-1:0]   step, up, own_clr, clr, ovf_ev;
  logic [3:0]       gev          [NCH];
  logic [21:0]      ev;
  logic             sync_any;

  assign access = i_wb.cyc && i_wb.stb && !ack_reg;
  assign wr     = access && i_wb.we;

  // ----------------------------------------------------------------------
  // Edge sources
  // ----------------------------------------------------------------------
  // The divided clocks are square waves on prescaler bits, so both-edge
  // counting on divide-by-4 gives a step every two cycles.
  always_comb begin
    ext_rise = ext_sync_reg & ~ext_prev_reg;
    ext_fall = ~ext_sync_reg & ext_prev_reg;
    pin_rise = pin_sync_reg & ~pin_prev_reg;
    pr_rise[0] = (&presc_reg[`DIV4_BIT-1:0]) & ~presc_reg[`DIV4_BIT];
    pr_fall[0] = (&presc_reg[`DIV4_BIT-1:0]) & presc_reg[`DIV4_BIT];
    pr_rise[1] = (&presc_reg[`DIV16_BIT-1:0]) & ~presc_reg[`DIV16_BIT];
    pr_fall[1] = (&presc_reg[`DIV16_BIT-1:0]) & presc_reg[`DIV16_BIT];
    pr_rise[2] = (&presc_reg[`DIV64_BIT-1:0]) & ~presc_reg[`DIV64_BIT];
    pr_fall[2] = (&presc_reg[`DIV64_BIT-1:0]) & presc_reg[`DIV64_BIT];
  end

  // ----------------------------------------------------------------------
  // Per-channel counting, events and clearing
  // ----------------------------------------------------------------------
  always_comb begin
    logic [2:0] src;
    logic [1:0] edg;
    logic       r, f, ign, tick;
    int         pa;
    src = '0;
    edg = '0;
    r = 1'b0;
    f = 1'b0;
    ign = 1'b0;
    tick = 1'b0;
    pa = 0;
    step = '0;
    up = '1;
    own_clr = '0;
    clr = '0;
    ovf_ev = '0;
    sync_any = 1'b0;
    ev = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      src = ctrl_reg[ch][`PSC_MSB:`PSC_LSB];
      edg = ctrl_reg[ch][`EDGE_MSB:`EDGE_LSB];
      ign = 1'b0;
      f = 1'b0;
      case (src)
        `PSC_DIV1: begin
          ign = 1'b1;
          r = 1'b1;
        end
        `PSC_DIV4: begin
          r = pr_rise[0];
          f = pr_fall[0];
        end
        `PSC_DIV16: begin
          r = pr_rise[1];
          f = pr_fall[1];
        end
        `PSC_DIV64: begin
          r = pr_rise[2];
          f = pr_fall[2];
        end
        default: begin
          if ((ch == 1 || ch == 4) && src == `PSC_CASCADE) begin
            ign = 1'b1;
            r = ovf_pulse_reg[ch-1];
          end else begin
            r = ext_rise[src[1:0]];
            f = ext_fall[src[1:0]];
          end
        end
      endcase
      if (ign) begin
        tick = r;
      end else if (edg[1]) begin
        tick = r | f;
      end else if (edg[0]) begin
        tick = f;
      end else begin
        tick = r;
      end
      if (phase_reg[ch]) begin
        pa = (ch == 1 || ch == 5) ? 0 : 2;
        tick = ext_rise[pa] | ext_fall[pa] | ext_rise[pa+1]
             | ext_fall[pa+1];
        up[ch] = ext_sync_reg[pa] ^ ext_prev_reg[pa+1];
      end
      step[ch] = tick & start_reg[ch];
      for (int k = 0; k < 4; k++) begin
        gev[ch][k] = 1'b0;
        if (gr_exists(ch, k)) begin
          if (pin_func_reg[pin_idx(ch, k)]) begin
            gev[ch][k] = step[ch] && (cnt_reg[ch] == gr_reg[ch][k]);
          end else begin
            gev[ch][k] = pin_rise[pin_idx(ch, k)];
          end
          // A buffering register never matches or captures.
          if (k >= 2 && ((ch == 0 && buffer_reg[0]) ||
                         (ch == 3 && buffer_reg[1]))) begin
            gev[ch][k] = 1'b0;
          end
          ev[pin_idx(ch, k)] = gev[ch][k];
        end
      end
      case (ctrl_reg[ch][`CLR_MSB:`CLR_LSB])
        `CLR_GR_A: own_clr[ch] = gev[ch][0];
        `CLR_GR_B: own_clr[ch] = gev[ch][1];
        `CLR_GR_C: own_clr[ch] = gev[ch][2];
        `CLR_GR_D: own_clr[ch] = gev[ch][3];
        default:   own_clr[ch] = 1'b0;
      endcase
      sync_any = sync_any | (own_clr[ch] & sync_reg[ch]);
    end
    for (int ch = 0; ch < NCH; ch++) begin
      clr[ch] = own_clr[ch] | (sync_any && sync_reg[ch] &&
                (ctrl_reg[ch][`CLR_LSB+1:`CLR_LSB] == `CLR_SYNC_LOW));
      ovf_ev[ch] = step[ch] && !clr[ch] &&
                   (up[ch] ? (cnt_reg[ch] == CNT_MAX)
                           : (cnt_reg[ch] == '0));
      ev[16+ch] = ovf_ev[ch];
    end
  end

  // ----------------------------------------------------------------------
  // Synchronisers and prescaler
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_meta_reg <= '0;
      ext_sync_reg <= '0;
      ext_prev_reg <= '0;
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
      presc_reg    <= '0;
    end else if (i_ce) begin
      ext_meta_reg <= {i_ext_clock_in_d, i_ext_clock_in_c,
                       i_ext_clock_in_b, i_ext_clock_in_a};
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
      pin_meta_reg <= i_gp_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      presc_reg    <= presc_reg + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Control, shared and configuration registers
  // ----------------------------------------------------------------------
  // Writes while a channel runs take effect at once; software is expected
  // to stop the channel first, since a mid-count change can skip an edge.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int ch = 0; ch < NCH; ch++) begin
        ctrl_reg[ch] <= `CTRL_RESET;
      end
      start_reg    <= '0;
      sync_reg     <= '0;
      phase_reg    <= '0;
      buffer_reg   <= '0;
      pin_func_reg <= '0;
      irq_mask_reg <= '0;
    end else if (i_ce && wr) begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (i_wb.adr == 8'(`OFS_CTRL_BASE + 4*ch)) begin
          ctrl_reg[ch] <= (ch == 0 || ch == 3)
            ? 8'(wmerge({24'h0, ctrl_reg[ch]}, i_wb))
            : 8'(wmerge({24'h0, ctrl_reg[ch]}, i_wb))
              & `CTRL_MASK_NARROW;
        end
      end
      case (i_wb.adr)
        `OFS_START:    start_reg <=
                         6'(wmerge({26'h0, start_reg}, i_wb));
        `OFS_SYNC:     sync_reg <=
                         6'(wmerge({26'h0, sync_reg}, i_wb));
        `OFS_PHASE:    phase_reg <=
                         6'(wmerge({26'h0, phase_reg}, i_wb))
                         & `PHASE_MASK;
        `OFS_BUFFER:   buffer_reg <=
                         2'(wmerge({30'h0, buffer_reg}, i_wb));
        `OFS_PIN_FUNC: pin_func_reg <=
                         16'(wmerge({16'h0, pin_func_reg}, i_wb));
        `OFS_IRQ_MASK: irq_mask_reg <=
                         22'(wmerge({10'h0, irq_mask_reg}, i_wb));
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int ch = 0; ch < NCH; ch++) begin
        cnt_reg[ch] <= '0;
      end
      ovf_pulse_reg <= '0;
    end else if (i_ce) begin
      ovf_pulse_reg <= ovf_ev;
      for (int ch = 0; ch < NCH; ch++) begin
        if (wr && i_wb.adr == 8'(`OFS_CNT_BASE + 4*ch)) begin
          cnt_reg[ch] <= CNT_W'(wmerge(32'(cnt_reg[ch]), i_wb));
        end else if (clr[ch]) begin
          cnt_reg[ch] <= '0;
        end else if (step[ch]) begin
          cnt_reg[ch] <= up[ch] ? cnt_reg[ch] + 1'b1
                                : cnt_reg[ch] - 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // General registers and pins
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int ch = 0; ch < NCH; ch++) begin
        for (int k = 0; k < 4; k++) begin
          gr_reg[ch][k] <= CNT_MAX;
        end
      end
      pin_out_reg <= '0;
    end else if (i_ce) begin
      for (int ch = 0; ch < NCH; ch++) begin
        for (int k = 0; k < 4; k++) begin
          if (gr_exists(ch, k)) begin
            if (wr && i_wb.adr == 8'(`OFS_GR_BASE + 16*ch + 4*k)) begin
              gr_reg[ch][k] <= CNT_W'(wmerge(32'(gr_reg[ch][k]), i_wb));
            end else if (gev[ch][k] && !pin_func_reg[pin_idx(ch, k)]) begin
              gr_reg[ch][k] <= cnt_reg[ch];
            end else if (k < 2 && gev[ch][k] &&
                         ((ch == 0 && buffer_reg[0]) ||
                          (ch == 3 && buffer_reg[1]))) begin
              gr_reg[ch][k] <= gr_reg[ch][k+2];
            end
            if (gev[ch][k] && pin_func_reg[pin_idx(ch, k)]) begin
              pin_out_reg[pin_idx(ch, k)] <=
                ~pin_out_reg[pin_idx(ch, k)];
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  // A new event beats a write-one-to-clear in the same cycle.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_status_reg <= '0;
      irq_reg        <= 1'b0;
    end else if (i_ce) begin
      if (wr && i_wb.adr == `OFS_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg &
                           ~22'(wmerge(32'h0, i_wb))) | ev;
      end else begin
        irq_status_reg <= irq_status_reg | ev;
      end
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone read and acknowledge
  // ----------------------------------------------------------------------
  always_comb begin
    rdata = 32'h0;
    for (int ch = 0; ch < NCH; ch++) begin
      if (i_wb.adr == 8'(`OFS_CTRL_BASE + 4*ch)) begin
        rdata = {24'h0, ctrl_reg[ch]};
      end
      if (i_wb.adr == 8'(`OFS_CNT_BASE + 4*ch)) begin
        rdata = 32'(cnt_reg[ch]);
      end
      for (int k = 0; k < 4; k++) begin
        if (gr_exists(ch, k) &&
            i_wb.adr == 8'(`OFS_GR_BASE + 16*ch + 4*k)) begin
          rdata = 32'(gr_reg[ch][k]);
        end
      end
    end
    case (i_wb.adr)
      `OFS_START:      rdata = {26'h0, start_reg};
      `OFS_SYNC:       rdata = {26'h0, sync_reg};
      `OFS_PHASE:      rdata = {26'h0, phase_reg};
      `OFS_BUFFER:     rdata = {30'h0, buffer_reg};
      `OFS_PIN_FUNC:   rdata = {16'h0, pin_func_reg};
      `OFS_IRQ_STATUS: rdata = {10'h0, irq_status_reg};
      `OFS_IRQ_MASK:   rdata = {10'h0, irq_mask_reg};
      default: ;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end else if (i_ce) begin
      ack_reg <= access;
      if (access && !i_wb.we) begin
        rdat_reg <= rdata;
      end
    end
  end

  assign o_wb        = '{ack: ack_reg, dat: rdat_reg};
  assign o_gp_pin    = pin_out_reg;
  assign o_gp_pin_oe = pin_func_reg;
  assign o_irq       = irq_reg;

endmodule : pulse_timer_unit

/* File: bench/pulse_timer_unit_checker.sv */
// Purpose: Concurrent checks on the bus answer and pin enables.
// Assumes: One clock domain; bound to the top module's ports.
// Notes:   Pin enables may only move through a pin function write.
`timescale 1ns/1ps
`include "pulse_timer_unit_defines.svh"
module pulse_timer_unit_checker
  import pulse_timer_unit_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  input  wire wb_req_s     i_wb,
  input  wire wb_rsp_s     o_wb,
  input  wire logic [15:0] o_gp_pin_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  logic take;
  logic rd;
  assign take = i_wb.cyc && i_wb.stb && !o_wb.ack && i_ce;
  assign rd   = take && !i_wb.we;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_ack_follows: assert property (take |=> o_wb.ack)
    else $error("ack missing after request");
  a_ack_single: assert property (o_wb.ack |=> !o_wb.ack)
    else $error("ack longer than one cycle");
  a_ack_unasked: assert property (
    !(i_wb.cyc && i_wb.stb) |=> !o_wb.ack)
    else $error("ack without request");
  a_ctrl_width: assert property (
    rd && i_wb.adr < `OFS_START && i_wb.adr[1:0] == 2'h0
    |=> o_wb.dat[31:8] == 24'h0)
    else $error("control read wider than eight bits");
  a_reserved_bit: assert property (
    rd && i_wb.adr inside {8'h04, 8'h08, 8'h10, 8'h14}
    |=> !o_wb.dat[7])
    else $error("reserved clear bit reads one");
  a_unmapped_zero: assert property (
    rd && i_wb.adr inside {[8'h4C:8'h7F]} |=> o_wb.dat == 32'h0)
    else $error("unmapped read not zero");
  a_dat_holds: assert property (!$past(rd) |-> $stable(o_wb.dat))
    else $error("read data moved without a read");
  a_oe_by_write: assert property (
    $changed(o_gp_pin_oe) |->
    o_wb.ack && i_wb.we && i_wb.adr == `OFS_PIN_FUNC)
    else $error("pin enable moved without a write");
endmodule : pulse_timer_unit_checker

/* File: bench/pulse_timer_unit_tb.sv */
// Purpose: Directed scenarios for the pulse timer unit.
// Assumes: Counter steps a few cycles after a synced external edge.
// Notes:   Control is only rewritten while channels are halted.
`timescale 1ns/1ps
`include "pulse_timer_unit_defines.svh"
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  err_total++; $display("wrong value at %0t: got %h expected %h", \
  $time, got, exp); end end
module pulse_timer_unit_tb;
  import pulse_timer_unit_pkg::*;
  localparam int CNT_W = 16;
  logic        i_clk;
  logic        i_arst_n;
  wb_req_s     wb;
  wb_rsp_s     rsp;
  logic [3:0]  ext;
  logic [15:0] pin_i;
  logic        ce;
  logic [15:0] pin_o;
  logic [15:0] pin_oe;
  logic        irq;
  logic [31:0] rdat;
  int          err_total;
  int          check_count;

  pulse_timer_unit #(.CNT_W(CNT_W)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(ce), .i_wb(wb),
    .o_wb(rsp), .i_ext_clock_in_a(ext[0]), .i_ext_clock_in_b(ext[1]),
    .i_ext_clock_in_c(ext[2]), .i_ext_clock_in_d(ext[3]),
    .i_gp_pin(pin_i), .o_gp_pin(pin_o), .o_gp_pin_oe(pin_oe),
    .o_irq(irq));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Entered just after a rising edge; returns one idle cycle later.
  task automatic wb_cycle(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
    int n;
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    rdat = rsp.dat;
    wb <= '0;
    if (n >= 20) begin
      err_total++;
      test_done();
    end
    @(posedge i_clk);
  endtask : wb_cycle

  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'b1, a, d);
  endtask : wb_write

  task automatic wb_read(input logic [7:0] a);
    wb_cycle(1'b0, a, 32'h0);
  endtask : wb_read

  // Four cycles per level keeps every edge well past the sync stages.
  task automatic level(input int b, input logic v);
    ext[b] <= v;
    repeat (4) @(posedge i_clk);
  endtask : level

  task automatic pulse(input int b, input int n);
    repeat (n) begin
      level(b, 1'b1);
      level(b, 1'b0);
    end
  endtask : pulse

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic reg_case;
    for (int ch = 0; ch < 6; ch++) begin
      wb_read(8'(ch * 4));
      `CHECK(rdat, 32'h0)
      wb_write(8'(ch * 4), 32'hFF);
      wb_read(8'(ch * 4));
      `CHECK(rdat, (ch == 0 || ch == 3) ? 32'hFF : 32'h7F)
      wb_write(8'(ch * 4), 32'h0);
    end
    wb_write(8'h4C, 32'h5A);
    wb_read(8'h4C);
    `CHECK(rdat, 32'h0)
    `CHECK(pin_oe, 16'h0000)
    wb_write(`OFS_PIN_FUNC, 32'hFFFF);
    `CHECK(pin_oe, 16'hFFFF)
    wb_write(`OFS_PIN_FUNC, 32'h0);
  endtask : reg_case

  task automatic edge_case(input logic [2:0] psc, input logic [1:0] edg,
                           input int n, input logic [15:0] exp);
    wb_write(`OFS_CTRL_BASE, {24'h0, 3'h0, edg, psc});
    wb_write(`OFS_CNT_BASE, 32'h0);
    wb_write(`OFS_START, 32'h1);
    pulse(int'(psc) - 4, n);
    wb_write(`OFS_START, 32'h0);
    wb_read(`OFS_CNT_BASE);
    `CHECK(rdat[15:0], exp)
    pulse(int'(psc) - 4, 1);
    wb_read(`OFS_CNT_BASE);
    `CHECK(rdat[15:0], exp)
  endtask : edge_case

  // Start commits one edge and stop three edges plus the wait later, so
  // the channel runs for exactly eight cycles whatever the prescaler phase.
  task automatic internal_case(input logic [2:0] psc,
                               input logic [1:0] edg,
                               input logic [15:0] exp);
    wb_write(`OFS_CTRL_BASE, {24'h0, 3'h0, edg, psc});
    wb_write(`OFS_CNT_BASE, 32'h0);
    wb_write(`OFS_START, 32'h1);
    repeat (5) @(posedge i_clk);
    wb_write(`OFS_START, 32'h0);
    wb_read(`OFS_CNT_BASE);
    `CHECK(rdat[15:0], exp)
  endtask : internal_case

  // Six cycles with the enable low must add nothing to the count.
  task automatic freeze_case;
    wb_write(`OFS_CTRL_BASE, 32'h0);
    wb_write(`OFS_CNT_BASE, 32'h0);
    wb_write(`OFS_START, 32'h1);
    ce <= 1'b0;
    repeat (6) @(posedge i_clk);
    ce <= 1'b1;
    wb_write(`OFS_START, 32'h0);
    wb_read(`OFS_CNT_BASE);
    `CHECK(rdat[15:0], 16'h0003)
  endtask : freeze_case

  // Falling edge is selected on purpose; phase mode must override it.
  task automatic phase_case(input int ch, input int a);
    wb_write(`OFS_PHASE, 32'h1 << ch);
    wb_write(8'(ch * 4), 32'h08);
    wb_write(8'(`OFS_CNT_BASE + ch * 4), 32'h0);
    wb_write(`OFS_START, 32'h1 << ch);
    repeat (2) begin
      level(a, 1'b1);
      level(a + 1, 1'b1);
      level(a, 1'b0);
      level(a + 1, 1'b0);
    end
    wb_write(`OFS_START, 32'h0);
    wb_read(8'(`OFS_CNT_BASE + ch * 4));
    `CHECK(rdat[15:0], 16'h0008)
    wb_write(`OFS_PHASE, 32'h0);
    wb_write(8'(ch * 4), 32'h0);
  endtask : phase_case

  task automatic clear_case;
    wb_write(`OFS_GR_BASE, 32'h2);
    wb_write(`OFS_PIN_FUNC, 32'h1);
    wb_write(`OFS_CTRL_BASE, 32'h24);
    wb_write(`OFS_CNT_BASE, 32'h0);
    wb_write(`OFS_START, 32'h1);
    pulse(0, 4);
    wb_write(`OFS_START, 32'h0);
    wb_read(`OFS_CNT_BASE);
    `CHECK(rdat[15:0], 16'h0001)
    `CHECK(pin_o[0], 1'b1)
    pin_i[1] <= 1'b1;
    repeat (4) @(posedge i_clk);
    wb_read(8'(`OFS_GR_BASE + 4));
    `CHECK(rdat[15:0], 16'h0001)
    pin_i[1] <= 1'b0;
    wb_write(`OFS_PIN_FUNC, 32'h0);
    wb_write(`OFS_IRQ_STATUS, 32'hFFFFFFFF);
  endtask : clear_case

  task automatic cascade_case;
    wb_write(`OFS_CTRL_BASE, 32'h04);
    wb_write(8'h04, 32'h0F);
    wb_write(`OFS_CNT_BASE, 32'hFFFE);
    wb_write(8'h24, 32'h0);
    wb_write(`OFS_IRQ_MASK, 32'h10000);
    wb_write(`OFS_START, 32'h3);
    pulse(0, 2);
    wb_write(`OFS_START, 32'h0);
    wb_read(8'h24);
    `CHECK(rdat[15:0], 16'h0001)
    wb_read(`OFS_CNT_BASE);
    `CHECK(rdat[15:0], 16'h0000)
    `CHECK(irq, 1'b1)
    wb_write(`OFS_IRQ_MASK, 32'h0);
    `CHECK(irq, 1'b0)
    wb_write(`OFS_IRQ_MASK, 32'h10000);
    `CHECK(irq, 1'b1)
    wb_read(`OFS_IRQ_STATUS);
    `CHECK(rdat[16], 1'b1)
    wb_write(`OFS_IRQ_STATUS, 32'h10000);
    `CHECK(irq, 1'b0)
  endtask : cascade_case

  // ----------------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    i_arst_n    = 1'b0;
    wb          = '0;
    ext         = 4'h0;
    pin_i       = 16'h0000;
    ce          = 1'b1;
    err_total   = 0;
    check_count = 0;
    repeat (16) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    reg_case();
    edge_case(3'h4, 2'h0, 3, 16'h0003);
    edge_case(3'h4, 2'h1, 3, 16'h0003);
    edge_case(3'h4, 2'h2, 3, 16'h0006);
    edge_case(3'h4, 2'h3, 3, 16'h0006);
    edge_case(3'h5, 2'h0, 2, 16'h0002);
    edge_case(3'h6, 2'h2, 2, 16'h0004);
    edge_case(3'h7, 2'h0, 2, 16'h0002);
    internal_case(3'h0, 2'h1, 16'h0008);
    internal_case(3'h1, 2'h0, 16'h0002);
    internal_case(3'h1, 2'h1, 16'h0002);
    internal_case(3'h1, 2'h2, 16'h0004);
    freeze_case();
    phase_case(1, 0);
    phase_case(2, 2);
    clear_case();
    cascade_case();
    test_done();
  end
endmodule : pulse_timer_unit_tb

bind pulse_timer_unit pulse_timer_unit_checker #(.CNT_W(CNT_W)) u_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_wb(i_wb),
  .o_wb(o_wb), .o_gp_pin_oe(o_gp_pin_oe));
